// ===== tdc_ro_regs.svh
// register offsets, field positions, opcodes and reset values of the readout opcode handler
// assumes a 32-bit axi4-lite slave port with byte addresses
`ifndef TDC_RO_REGS_SVH
`define TDC_RO_REGS_SVH
// ==================================================
// register byte offsets
`define RO_CMD_OFS 8'h00
`define RO_STATUS_OFS 8'h04
`define RO_CFG_OFS 8'h08
`define RO_ERRSTAT_OFS 8'h0c
`define RO_OVFCNT_OFS 8'h10
// ==================================================
// opcode upper bytes
`define OP_HT_ON 8'h30
`define OP_HT_OFF 8'h31
`define OP_HT_READ 8'h32
`define OP_HITS_SET 8'h33
`define OP_HITS_READ 8'h34
`define OP_MARK_ON 8'h35
`define OP_MARK_OFF 8'h36
`define OP_BYP_ON 8'h37
`define OP_BYP_OFF 8'h38
`define OP_ERRMASK_SET 8'h39
`define OP_ERRMASK_READ 8'h3a
`define OP_L1_SET 8'h3b
`define OP_L1_READ 8'h3c
// ==================================================
// reset values and encodings
`define RST_HT_EN 1'b0
`define RST_MARK_EN 1'b1
`define RST_BYP_EN 1'b0
`define RST_HITS_CODE 4'h9
`define RST_ERR_MASK 11'h7ff
`define RST_L1_CODE 3'h7
`define RST_L1_DEPTH 9'h100
`define HITS_CODE_MAX 4'h8
`define SIZE_ERR_FLAG 16'h1000
// ==================================================
// cfg register field positions
`define CFG_HT_BIT 0
`define CFG_MARK_BIT 1
`define CFG_BYP_BIT 2
`define CFG_HITS_LSB 4
`define CFG_L1_LSB 8
`define CFG_MASK_LSB 16
`endif

// ===== tdc_ro_pkg.sv
// types shared by the readout opcode handler and its event limiter
// assumes nothing beyond the register header
package tdc_ro_pkg;
  // ==================================================
  // event stream
  typedef enum logic [1:0] {EVT_HDR, EVT_HIT, EVT_TRL, EVT_ERR} evt_kind_e;
  typedef struct packed {
    evt_kind_e kind;
    logic [23:0] data;
  } evt_word_s;
  // ==================================================
  // command interpreter
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_PARAM, ST_WAIT_READ} cmd_state_e;
  typedef struct packed {
    logic [10:0] err_mask;
    logic [2:0] l1_code;
    logic [3:0] hits_code;
    logic bypass_en;
    logic mark_en;
    logic ht_en;
  } ro_cfg_s;
endpackage : tdc_ro_pkg

// ===== axil_slave.sv
// axi4-lite slave front end: one write and one read under way at a time
// assumes the owner answers rd_data and error flags in the cycle of the strobe
`timescale 1ns/1ps
module axil_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_held_reg;
  logic w_held_reg;
  logic rd_pend_reg;
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire ar_take = arvalid & arready;
  // both halves in hand and no response outstanding
  assign wr_en = aw_held_reg & w_held_reg & ~bvalid;
  assign rd_en = rd_pend_reg;
  assign awready = ~aw_held_reg & ~bvalid;
  assign wready = ~w_held_reg & ~bvalid;
  assign arready = ~rd_pend_reg & ~rvalid;
  // ==================================================
  // write channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      wr_addr <= '0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end else if (ce) begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        wr_addr <= awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_err ? 2'h2 : 2'h0;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // ==================================================
  // read channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_pend_reg <= 1'b0;
      rd_addr <= '0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else if (ce) begin
      if (ar_take) begin
        rd_pend_reg <= 1'b1;
        rd_addr <= araddr;
      end
      if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_data;
        rresp <= rd_err ? 2'h2 : 2'h0;
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule : axil_slave

// ===== evt_limiter.sv
// per-event hit limiter and header/trailer filter on the readout stream
// assumes one word per cycle and that the source honours in_ready
`timescale 1ns/1ps
`include "tdc_ro_regs.svh"
module evt_limiter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic in_valid,
  input wire tdc_ro_pkg::evt_word_s in_evt,
  output logic in_ready,
  input wire logic ht_en,
  input wire logic [3:0] hits_code,
  output logic out_valid,
  output tdc_ro_pkg::evt_word_s out_evt,
  output logic ovf_pulse
);
  logic [8:0] hits_reg;
  logic ovf_reg;
  logic pend_reg;
  tdc_ro_pkg::evt_word_s trl_reg;
  wire take = in_valid & in_ready;
  wire limit_on = hits_code <= `HITS_CODE_MAX;
  wire [8:0] limit = (hits_code == 4'h0) ? 9'h0 : 9'(9'h1 << (hits_code - 4'h1));
  wire room = ~limit_on | (hits_reg < limit);
  wire is_hdr = in_evt.kind == tdc_ro_pkg::EVT_HDR;
  wire is_hit = in_evt.kind == tdc_ro_pkg::EVT_HIT;
  wire is_trl = in_evt.kind == tdc_ro_pkg::EVT_TRL;
  wire err_now = take & is_trl & ovf_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hits_reg <= 9'h0;
      ovf_reg <= 1'b0;
      pend_reg <= 1'b0;
      trl_reg <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_evt <= '0;
      ovf_pulse <= 1'b0;
    end else if (ce) begin
      ovf_pulse <= err_now;
      out_valid <= 1'b0;
      if (pend_reg) begin
        // held trailer follows the error word
        out_valid <= 1'b1;
        out_evt <= trl_reg;
        pend_reg <= 1'b0;
        in_ready <= 1'b1;
      end else if (take) begin
        if (is_hdr | is_trl) begin
          hits_reg <= 9'h0;
          ovf_reg <= 1'b0;
        end
        if (err_now) begin
          out_valid <= 1'b1;
          out_evt <= '{kind: tdc_ro_pkg::EVT_ERR, data: {8'h00, `SIZE_ERR_FLAG}};
          trl_reg <= in_evt;
          pend_reg <= ht_en;
          in_ready <= ~ht_en;
        end else if (is_hit) begin
          if (room) begin
            out_valid <= 1'b1;
            out_evt <= in_evt;
            hits_reg <= hits_reg + 9'h1;
          end else begin
            ovf_reg <= 1'b1;
          end
        end else begin
          out_valid <= ht_en;
          out_evt <= in_evt;
        end
      end
    end
  end
endmodule : evt_limiter

// ===== tdc_readout_opcode_handler.sv
// readout opcode interpreter: opcode and parameter words through one command register
// assumes an axi4-lite master and a readout stream on the same clock
`timescale 1ns/1ps
`include "tdc_ro_regs.svh"
module tdc_readout_opcode_handler #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [10:0] err_active,
  input wire logic in_valid,
  input wire tdc_ro_pkg::evt_word_s in_evt,
  output logic in_ready,
  output logic out_valid,
  output tdc_ro_pkg::evt_word_s out_evt,
  output tdc_ro_pkg::ro_cfg_s cfg,
  output logic [8:0] level_one_hit_buffer_depth,
  output logic global_error,
  output logic busy
);
  // ==================================================
  // parameter checks
  if (ADDR_W < 5) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end
  // ==================================================
  // bus front end
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_err;
  logic rd_err;
  axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );
  // ==================================================
  // address decode
  wire [7:0] wr_ofs = 8'(wr_addr);
  wire [7:0] rd_ofs = 8'(rd_addr);
  wire wr_cmd = wr_ofs == `RO_CMD_OFS;
  wire wr_ro = (wr_ofs == `RO_STATUS_OFS) | (wr_ofs == `RO_CFG_OFS) | (wr_ofs == `RO_ERRSTAT_OFS) |
    (wr_ofs == `RO_OVFCNT_OFS);
  wire rd_cmd = rd_ofs == `RO_CMD_OFS;
  wire rd_status = rd_ofs == `RO_STATUS_OFS;
  wire rd_cfg = rd_ofs == `RO_CFG_OFS;
  wire rd_errstat = rd_ofs == `RO_ERRSTAT_OFS;
  wire rd_ovfcnt = rd_ofs == `RO_OVFCNT_OFS;
  assign wr_err = ~(wr_cmd | wr_ro);
  assign rd_err = ~(rd_cmd | rd_status | rd_cfg | rd_errstat | rd_ovfcnt);
  // writes to the command word without both low byte strobes are dropped, a half opcode would mis-decode
  wire word_ok = wr_strb[1:0] == 2'h3;
  wire cmd_wr = wr_en & wr_cmd & word_ok;
  wire cmd_rd = rd_en & rd_cmd;
  // ==================================================
  // interpreter state
  tdc_ro_pkg::cmd_state_e state_reg;
  tdc_ro_pkg::cmd_state_e state_next;
  logic [7:0] op_reg;
  logic [7:0] op_next;
  logic [15:0] rb_reg;
  logic [15:0] rb_next;
  tdc_ro_pkg::ro_cfg_s cfg_next;
  logic [15:0] ovf_cnt_reg;
  logic ovf_pulse;
  wire [7:0] opcode = wr_data[15:8];
  wire [15:0] param = wr_data[15:0];
  wire [15:0] ht_word = {15'h0, cfg.ht_en};
  wire [15:0] hits_word = {12'h0, cfg.hits_code};
  wire [15:0] mask_word = {5'h0, cfg.err_mask};
  wire [15:0] l1_word = {13'h0, cfg.l1_code};
  wire in_idle = state_reg == tdc_ro_pkg::ST_IDLE;
  wire in_param = state_reg == tdc_ro_pkg::ST_WAIT_PARAM;
  wire in_read = state_reg == tdc_ro_pkg::ST_WAIT_READ;
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    rb_next = rb_reg;
    cfg_next = cfg;
    case (state_reg)
      tdc_ro_pkg::ST_IDLE: begin
        if (cmd_wr) begin
          op_next = opcode;
          case (opcode)
            `OP_HT_ON: cfg_next.ht_en = 1'b1;
            `OP_HT_OFF: cfg_next.ht_en = 1'b0;
            `OP_MARK_ON: cfg_next.mark_en = 1'b1;
            `OP_MARK_OFF: cfg_next.mark_en = 1'b0;
            `OP_BYP_ON: cfg_next.bypass_en = 1'b1;
            `OP_BYP_OFF: cfg_next.bypass_en = 1'b0;
            `OP_HITS_SET, `OP_ERRMASK_SET, `OP_L1_SET: begin
              state_next = tdc_ro_pkg::ST_WAIT_PARAM;
            end
            `OP_HT_READ: begin
              rb_next = ht_word;
              state_next = tdc_ro_pkg::ST_WAIT_READ;
            end
            `OP_HITS_READ: begin
              rb_next = hits_word;
              state_next = tdc_ro_pkg::ST_WAIT_READ;
            end
            `OP_ERRMASK_READ: begin
              rb_next = mask_word;
              state_next = tdc_ro_pkg::ST_WAIT_READ;
            end
            `OP_L1_READ: begin
              rb_next = l1_word;
              state_next = tdc_ro_pkg::ST_WAIT_READ;
            end
            default: begin
              op_next = op_reg;
            end
          endcase
        end
      end
      tdc_ro_pkg::ST_WAIT_PARAM: begin
        // stays here until the parameter word lands
        if (cmd_wr) begin
          case (op_reg)
            `OP_HITS_SET: cfg_next.hits_code = param[3:0];
            `OP_ERRMASK_SET: cfg_next.err_mask = param[10:0];
            `OP_L1_SET: cfg_next.l1_code = param[2:0];
            default: cfg_next = cfg;
          endcase
          state_next = tdc_ro_pkg::ST_IDLE;
        end
      end
      tdc_ro_pkg::ST_WAIT_READ: begin
        // writes are ignored until the answer is collected
        if (cmd_rd) begin
          state_next = tdc_ro_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = tdc_ro_pkg::ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= tdc_ro_pkg::ST_IDLE;
      op_reg <= 8'h00;
      rb_reg <= 16'h0000;
    end else if (ce) begin
      state_reg <= state_next;
      op_reg <= op_next;
      rb_reg <= rb_next;
    end
  end
  // ==================================================
  // configuration outputs
  wire [8:0] depth_next = 9'(9'h2 << cfg_next.l1_code);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg.ht_en <= `RST_HT_EN;
      cfg.mark_en <= `RST_MARK_EN;
      cfg.bypass_en <= `RST_BYP_EN;
      cfg.hits_code <= `RST_HITS_CODE;
      cfg.err_mask <= `RST_ERR_MASK;
      cfg.l1_code <= `RST_L1_CODE;
      level_one_hit_buffer_depth <= `RST_L1_DEPTH;
    end else if (ce) begin
      cfg <= cfg_next;
      level_one_hit_buffer_depth <= depth_next;
    end
  end
  // ==================================================
  // global error
  wire [10:0] err_live = err_active & cfg.err_mask;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      global_error <= 1'b0;
      busy <= 1'b0;
    end else if (ce) begin
      global_error <= |err_live;
      busy <= state_next != tdc_ro_pkg::ST_IDLE;
    end
  end
  // ==================================================
  // readout stream
  evt_limiter u_limit (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(in_valid),
    .in_evt(in_evt),
    .in_ready(in_ready),
    .ht_en(cfg.ht_en),
    .hits_code(cfg.hits_code),
    .out_valid(out_valid),
    .out_evt(out_evt),
    .ovf_pulse(ovf_pulse)
  );
  // count wraps; software takes differences
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ovf_cnt_reg <= 16'h0000;
    end else if (ce && ovf_pulse) begin
      ovf_cnt_reg <= ovf_cnt_reg + 16'h0001;
    end
  end
  // ==================================================
  // read mux
  wire [31:0] cmd_rd_word = in_read ? {16'h0000, rb_reg} : 32'h0;
  wire [31:0] status_word = {16'h0, op_reg, 4'h0, global_error, in_read, in_param, in_idle};
  wire [31:0] cfg_word = {5'h0, cfg.err_mask, 5'h0, cfg.l1_code, cfg.hits_code, 1'b0, cfg.bypass_en,
    cfg.mark_en, cfg.ht_en};
  wire [31:0] errstat_word = {5'h0, err_live, 5'h0, err_active};
  wire [31:0] ovfcnt_word = {16'h0, ovf_cnt_reg};
  assign rd_data = rd_cmd ? cmd_rd_word :
    rd_status ? status_word :
    rd_cfg ? cfg_word :
    rd_errstat ? errstat_word :
    rd_ovfcnt ? ovfcnt_word : 32'h0;
endmodule : tdc_readout_opcode_handler

// ===== tdc_readout_opcode_handler_props.sv
// port checker for the readout opcode handler
// assumes one clock, synchronous reset, bound from the bench
`timescale 1ns/1ps
`include "tdc_ro_regs.svh"
module tdc_readout_opcode_handler_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [10:0] err_active,
  input wire logic in_valid,
  input wire tdc_ro_pkg::evt_word_s in_evt,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire tdc_ro_pkg::evt_word_s out_evt,
  input wire tdc_ro_pkg::ro_cfg_s cfg,
  input wire logic [8:0] level_one_hit_buffer_depth,
  input wire logic global_error
);
  // ==========
  // helpers
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic gerr_exp = |(err_active & cfg.err_mask);
  sequence wr_taken;
    awvalid && awready && wvalid && wready && ce;
  endsequence
  sequence hdr_taken;
    in_valid && in_ready && ce && in_evt.kind == tdc_ro_pkg::EVT_HDR;
  endsequence
  // ==========
  // assertions
  chk_gerr_follow: assert property (ce |=> global_error == $past(gerr_exp))
    else $error("global error not following enabled errors");
  chk_depth_code: assert property (level_one_hit_buffer_depth == (9'h002 << cfg.l1_code))
    else $error("buffer depth does not match code");
  chk_rst_cfg: assert property ($fell(sys_rst) |-> cfg.hits_code == `RST_HITS_CODE && cfg.mark_en
    && cfg.err_mask == `RST_ERR_MASK && cfg.l1_code == `RST_L1_CODE && !cfg.ht_en && !cfg.bypass_en)
    else $error("settings wrong after reset");
  chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  chk_wr_answer: assert property (wr_taken |-> ##2 bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (arvalid && arready && ce |-> ##2 rvalid)
    else $error("read data late");
  chk_hdr_gate: assert property (hdr_taken and !cfg.ht_en |=> !out_valid)
    else $error("header passed while disabled");
  chk_hdr_pass: assert property (hdr_taken and cfg.ht_en |=> out_valid && out_evt == $past(in_evt))
    else $error("header not passed while enabled");
  chk_hit_zero: assert property (in_valid && in_ready && in_evt.kind == tdc_ro_pkg::EVT_HIT
    && cfg.hits_code == 4'h0 |=> !out_valid)
    else $error("hit passed with zero limit");
endmodule : tdc_readout_opcode_handler_props

// ===== axil_host.sv
// axi4-lite host model issuing opcodes and parameter words
// assumes slave outputs change only at rising edges
`timescale 1ns/1ps
module axil_host (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  // ==========
  // write: one whole word per call, handshakes judged before the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ta;
    logic tw;
    logic tb;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge clk);
      // released lines show the inverse, not a stale value
      if (ta) awaddr <= ~a;
      if (ta) awvalid <= 1'b0;
      if (tw) wdata <= ~d;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ta;
    logic tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ta) araddr <= ~a;
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd
endmodule : axil_host

// ===== tdc_readout_opcode_handler_bench.sv
// self-checking bench for the readout opcode handler
// assumes host model, checker and design compiled first
`timescale 1ns/1ps
`include "tdc_ro_regs.svh"
module tdc_readout_opcode_handler_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [10:0] err_active = 11'h000;
  logic in_valid = 1'b0;
  tdc_ro_pkg::evt_word_s in_evt = '0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic in_ready, out_valid, global_error, busy;
  tdc_ro_pkg::evt_word_s out_evt;
  tdc_ro_pkg::ro_cfg_s cfg;
  logic [8:0] level_one_hit_buffer_depth;
  logic [31:0] rd_word;
  tdc_ro_pkg::evt_word_s outq[$];
  int n_mismatch = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  tdc_readout_opcode_handler u_tdc_readout_opcode_handler (.clk, .sys_rst, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .err_active, .in_valid, .in_evt, .in_ready, .out_valid, .out_evt, .cfg,
    .level_one_hit_buffer_depth, .global_error, .busy);
  axil_host u_axil_host (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  always @(negedge clk) if (out_valid === 1'b1) outq.push_back(out_evt);
  // ==========
  // helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cmd(input logic [15:0] w);
    u_axil_host.wr(`RO_CMD_OFS, {16'h0000, w}, resp);
    @(negedge clk);
  endtask : cmd
  task automatic rb(input logic [7:0] op, output logic [31:0] d);
    cmd({op, 8'h5a});
    u_axil_host.rd(`RO_CMD_OFS, d, resp);
  endtask : rb
  task automatic send(input tdc_ro_pkg::evt_kind_e k, input logic [23:0] d);
    logic t;
    @(posedge clk);
    in_valid <= 1'b1;
    in_evt <= {k, d};
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = in_ready;
      if (!t) @(posedge clk);
    end
  endtask : send
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // ==========
  // scenarios
  task automatic t_defaults;
    u_axil_host.rd(`RO_CFG_OFS, rd_word, resp);
    chk("cfg reg", 32'h07ff0792, rd_word);
    rb(`OP_HITS_READ, rd_word);
    chk("hits rb", 32'h00000009, rd_word);
    rb(`OP_ERRMASK_READ, rd_word);
    chk("mask rb", 32'h000007ff, rd_word);
    rb(`OP_L1_READ, rd_word);
    chk("depth code rb", 32'h00000007, rd_word);
  endtask : t_defaults
  task automatic t_flags;
    logic [7:0] ops [6] = '{`OP_HT_ON, `OP_MARK_OFF, `OP_BYP_ON, `OP_HT_OFF, `OP_MARK_ON, `OP_BYP_OFF};
    logic [2:0] exp [6] = '{3'h3, 3'h1, 3'h5, 3'h4, 3'h6, 3'h2};
    for (int i = 0; i < 6; i++) begin
      cmd({ops[i], ~ops[i]});
      chk("flags", {29'h0, exp[i]}, {29'h0, cfg.bypass_en, cfg.mark_en, cfg.ht_en});
      rb(`OP_HT_READ, rd_word);
      chk("ht rb", {31'h0, exp[i][0]}, rd_word);
    end
  endtask : t_flags
  task automatic t_params;
    cmd({`OP_HITS_SET, 8'hff});
    chk("busy param", 32'h00000001, {31'h0, busy});
    cmd(16'hfff4);
    chk("busy done", 32'h00000000, {31'h0, busy});
    rb(`OP_HITS_READ, rd_word);
    chk("hits rb", 32'h00000004, rd_word);
    cmd({`OP_ERRMASK_SET, 8'h00});
    cmd(16'hf855);
    rb(`OP_ERRMASK_READ, rd_word);
    chk("mask rb", 32'h00000055, rd_word);
    cmd({`OP_L1_SET, 8'h11});
    cmd(16'hfffb);
    rb(`OP_L1_READ, rd_word);
    chk("depth code rb", 32'h00000003, rd_word);
    chk("depth", 32'h00000010, {23'h0, level_one_hit_buffer_depth});
    cmd({`OP_HT_READ, 8'h00});
    cmd({`OP_HT_ON, 8'h00});
    chk("busy read", 32'h00000001, {31'h0, busy});
    u_axil_host.rd(`RO_CMD_OFS, rd_word, resp);
    chk("ht rb", 32'h00000000, rd_word);
    chk("ht held", 32'h00000000, {31'h0, cfg.ht_en});
  endtask : t_params
  task automatic t_gerr;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      err_active <= 11'h001 << i;
      @(posedge clk);
      @(negedge clk);
      chk("global error", {31'h0, i[0] == 1'b0 && i != 8 && i != 10}, {31'h0, global_error});
    end
    @(posedge clk);
    err_active <= 11'h000;
  endtask : t_gerr
  task automatic t_stream;
    tdc_ro_pkg::evt_word_s exp [4] = '{{tdc_ro_pkg::EVT_HDR, 24'h0000a1}, {tdc_ro_pkg::EVT_HIT, 24'h000011},
      {tdc_ro_pkg::EVT_ERR, 24'h001000}, {tdc_ro_pkg::EVT_TRL, 24'h0000b2}};
    cmd({`OP_HITS_SET, 8'h00});
    cmd(16'h0001);
    cmd({`OP_HT_ON, 8'h00});
    outq.delete();
    send(tdc_ro_pkg::EVT_HDR, 24'h0000a1);
    send(tdc_ro_pkg::EVT_HIT, 24'h000011);
    send(tdc_ro_pkg::EVT_HIT, 24'h000022);
    send(tdc_ro_pkg::EVT_TRL, 24'h0000b2);
    @(posedge clk);
    in_valid <= 1'b0;
    @(negedge clk);
    chk("in ready", 32'h00000000, {31'h0, in_ready});
    repeat (4) @(posedge clk);
    chk("out count", 32'h00000004, 32'(outq.size()));
    for (int i = 0; i < 4 && i < outq.size(); i++) chk("out word", {6'h0, exp[i]}, {6'h0, outq[i]});
    cmd({`OP_HITS_SET, 8'h00});
    cmd(16'h0000);
    cmd({`OP_HT_OFF, 8'h00});
    outq.delete();
    send(tdc_ro_pkg::EVT_HDR, 24'h0000a2);
    send(tdc_ro_pkg::EVT_HIT, 24'h000033);
    send(tdc_ro_pkg::EVT_TRL, 24'h0000b3);
    @(posedge clk);
    in_valid <= 1'b0;
    @(negedge clk);
    chk("in ready", 32'h00000001, {31'h0, in_ready});
    repeat (4) @(posedge clk);
    chk("out count", 32'h00000001, 32'(outq.size()));
    if (outq.size() > 0) chk("err word", {6'h0, exp[2]}, {6'h0, outq[0]});
    u_axil_host.rd(`RO_OVFCNT_OFS, rd_word, resp);
    chk("ovf count", 32'h00000002, rd_word);
  endtask : t_stream
  task automatic t_unmapped;
    u_axil_host.wr(8'h20, 32'h00000000, resp);
    chk("bresp", 32'h00000002, {30'h0, resp});
    u_axil_host.rd(8'h20, rd_word, resp);
    chk("rresp", 32'h00000002, {30'h0, resp});
  endtask : t_unmapped
  // ==========
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_defaults();
    t_flags();
    t_params();
    t_gerr();
    t_stream();
    t_unmapped();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tdc_readout_opcode_handler_bench
bind tdc_readout_opcode_handler tdc_readout_opcode_handler_props u_props (.clk, .sys_rst, .ce, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .err_active, .in_valid, .in_evt, .in_ready, .out_valid, .out_evt, .cfg, .level_one_hit_buffer_depth,
  .global_error);
